// file: misc_exec_regs.svh
`ifndef MISC_EXEC_REGS_SVH
`define MISC_EXEC_REGS_SVH

// Operand and result widths
`define EXEC_DATA_W 8
`define EXEC_ADDR_W 7
`define EXEC_PC_W 15
// Program counter field split for the accumulator call
`define EXEC_PC_LO_MSB 7
`define EXEC_PC_HI_LSB 8
// Constant results
`define EXEC_ZERO_BYTE 8'h00
`define EXEC_ONE_BYTE 8'h01
// Cycle counts
`define EXEC_ONE_CYCLE 2'h1
`define EXEC_TWO_CYCLES 2'h2
// Reset values
`define EXEC_PC_RESET 15'h0000

`endif

// file: misc_exec_pkg.sv
package misc_exec_pkg;

   // Instruction selector handed in by the opcode decoder
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_CALL_VIA_ACCUMULATOR = 3'h1,
      OP_COMPLEMENT_FILE = 3'h2,
      OP_CLEAR_FILE = 3'h3,
      OP_CLEAR_ACCUMULATOR = 3'h4,
      OP_DECREMENT_FILE = 3'h5,
      OP_DECREMENT_SKIP_ZERO = 3'h6,
      OP_INCREMENT_SKIP_ZERO = 3'h7
   } misc_op_e;

   // Execution sequencer states; either busy state is one bit away from issue
   typedef enum logic [1:0] {
      ST_ISSUE = 2'h0,
      ST_SECOND = 2'h1,
      ST_FLUSH = 2'h2
   } exec_state_e;

   // One issued instruction
   typedef struct packed {
      misc_op_e op;
      logic [6:0] file_addr;
      logic dest_file;
      logic [7:0] file_data;
      logic [7:0] accum;
      logic [6:0] pc_latch_high;
      logic [14:0] pc;
   } exec_req_s;

   // Write-back and flag outputs
   typedef struct packed {
      logic acc_we;
      logic file_we;
      logic [6:0] file_addr;
      logic [7:0] data;
      logic zero_we;
      logic zero;
   } exec_wb_s;

   // Return stack push and program counter load
   typedef struct packed {
      logic push;
      logic [14:0] ret_addr;
      logic pc_load;
      logic [14:0] pc_target;
   } exec_flow_s;

endpackage

// file: cpu_misc_instruction_exec.sv
`timescale 1ns/1ps
`include "misc_exec_regs.svh"
// Contract
// - Accumulator call pushes next instruction address before changing program counter.
// - Call target: accumulator into bits 7:0, latch 6:0 into 14:8, flags kept.
// - Accumulator call takes two instruction cycles.
// - Complement inverts file register, destination bit picks accumulator or file, zero updated.
// - Clear file writes 00h into file register and sets zero flag.
// - Clear accumulator writes 00h into accumulator and sets zero flag.
// - Decrement subtracts one, destination bit routes result, zero flag updated.
// - Decrement-and-skip subtracts one, routes by destination, flags unchanged.
// - Zero result of decrement-and-skip discards next instruction as two-cycle no-operation.
// - Increment-and-skip adds one, routes, skips on zero, flags unchanged.
module cpu_misc_instruction_exec (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic issue_i,
   input wire misc_exec_pkg::exec_req_s req_i,
   output logic busy_o,
   output logic done_o,
   output logic discard_next_o,
   output misc_exec_pkg::exec_wb_s wb_o,
   output misc_exec_pkg::exec_flow_s flow_o,
   output logic [1:0] cycles_o
);
   import misc_exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers
   function automatic logic [7:0] step_byte(input logic [7:0] v, input logic up);
      step_byte = up ? 8'(v + `EXEC_ONE_BYTE) : 8'(v - `EXEC_ONE_BYTE);
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == `EXEC_ZERO_BYTE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the issued operation
   // A request seen while busy is dropped, not queued
   wire take = issue_i & ~busy_o;
   wire is_call = req_i.op == OP_CALL_VIA_ACCUMULATOR;
   wire is_comp = req_i.op == OP_COMPLEMENT_FILE;
   wire is_clear_file = req_i.op == OP_CLEAR_FILE;
   wire is_clear_acc = req_i.op == OP_CLEAR_ACCUMULATOR;
   wire is_dec = req_i.op == OP_DECREMENT_FILE;
   wire is_dsz = req_i.op == OP_DECREMENT_SKIP_ZERO;
   wire is_isz = req_i.op == OP_INCREMENT_SKIP_ZERO;
   // Every op that routes a stepped value by the destination bit
   wire is_step = is_dec | is_dsz | is_isz;

   // Result selection; clears force zero
   // stepped value: plus one for increment-and-skip, minus one otherwise
   wire [7:0] step_val = step_byte(req_i.file_data, is_isz);
   wire [7:0] next_result = is_comp ? ~req_i.file_data :
                            is_step ? step_val : `EXEC_ZERO_BYTE;
   // skip when stepped result is zero
   wire skip_hit = (is_dsz | is_isz) & is_zero(step_val);

   // call target from accumulator and latch
   wire [14:0] call_target = {req_i.pc_latch_high, req_i.accum};
   // return address is the following instruction
   wire [14:0] next_ret = 15'(req_i.pc + 15'h0001);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: second cycle of a call, or the flushed slot of a skip
   exec_state_e state;
   exec_state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         ST_ISSUE: begin
            if (take && is_call) begin
               next_state = ST_SECOND;
            end else if (take && skip_hit) begin
               next_state = ST_FLUSH;
            end
         end
         ST_SECOND: next_state = ST_ISSUE;
         // The flushed slot lasts exactly one cycle
         ST_FLUSH: next_state = ST_ISSUE;
         default: next_state = ST_ISSUE;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state <= ST_ISSUE;
      end else begin
         state <= next_state;
      end
   end

   // Combinational, so a request in a busy cycle is refused in that same cycle
   assign busy_o = (state != ST_ISSUE);

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs; strobes are one-cycle pulses, cycles_o and the call addresses hold
   exec_wb_s next_wb;
   exec_flow_s next_flow;
   always_comb begin
      next_wb = '0;
      next_wb.file_addr = req_i.file_addr;
      next_wb.data = next_result;
      if (take) begin
         if (is_comp || is_step) begin
            next_wb.acc_we = ~req_i.dest_file;
            next_wb.file_we = req_i.dest_file;
         end
         if (is_clear_file) begin
            next_wb.file_we = 1'b1;
         end
         if (is_clear_acc) begin
            next_wb.acc_we = 1'b1;
         end
         // zero flag from the 8-bit result; skips leave flags alone
         next_wb.zero_we = is_comp | is_dec | is_clear_file | is_clear_acc;
         next_wb.zero = is_zero(next_result);
      end
   end

   // Push goes out in the first cycle, the counter load in the second,
   // so the stack always holds the return before the jump lands
   always_comb begin
      next_flow = flow_o;
      next_flow.push = 1'b0;
      next_flow.pc_load = 1'b0;
      if (take && is_call) begin
         next_flow.push = 1'b1;
         next_flow.ret_addr = next_ret;
         next_flow.pc_target = call_target;
      end
      if (state == ST_SECOND) begin
         next_flow.pc_load = 1'b1;
      end
   end

   // Output flops
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         wb_o <= '0;
         flow_o <= '0;
         done_o <= 1'b0;
         discard_next_o <= 1'b0;
         cycles_o <= 2'h0;
      end else begin
         wb_o <= next_wb;
         flow_o <= next_flow;
         done_o <= (take && !is_call) || state == ST_SECOND;
         // discard flag marks the no-operation slot
         discard_next_o <= take && skip_hit;
         // Cycle count stands until the next taken instruction
         if (take) begin
            cycles_o <= (is_call || skip_hit) ? `EXEC_TWO_CYCLES : `EXEC_ONE_CYCLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Call: return pushed first, jump one cycle later, never both at once
   a_call_push_order: assert property (
      flow_o.push |=> flow_o.pc_load && !flow_o.push)
      else $error("call load did not follow push");

   a_call_ret_addr: assert property (
      (take && is_call) |=> flow_o.push && !flow_o.pc_load
         && flow_o.ret_addr == 15'($past(req_i.pc) + 15'h0001))
      else $error("call return address wrong");

   // A load with no push ahead of it would lose the return address
   a_load_after_push: assert property (
      flow_o.pc_load |-> $past(flow_o.push))
      else $error("program counter load without push");

   // Target rebuilt from the operands, held while the load goes out
   a_call_target_bits: assert property (
      (take && is_call) |-> ##2 flow_o.pc_load
         && flow_o.pc_target == {$past(req_i.pc_latch_high, 2), $past(req_i.accum, 2)})
      else $error("call target wrong");

   // Neither cycle of a call may touch data or flags
   a_call_no_write: assert property (
      (take && is_call) |=> (!wb_o.acc_we && !wb_o.file_we && !wb_o.zero_we)
         ##1 (!wb_o.acc_we && !wb_o.file_we && !wb_o.zero_we))
      else $error("call wrote data or flags");

   a_call_two_cycles: assert property (
      (take && is_call) |=> busy_o ##1 (!busy_o && done_o))
      else $error("call not two cycles");

   a_call_cycle_count: assert property (
      (take && is_call) |=> cycles_o == 2'h2)
      else $error("call cycle count wrong");

   // A request during the second call cycle must leave no trace
   a_busy_refuses: assert property (
      (issue_i && state == ST_SECOND) |=> !wb_o.acc_we && !wb_o.file_we
         && !wb_o.zero_we && !flow_o.push)
      else $error("request taken while busy");

   // Data instructions: result, routing by the destination bit, flag write
   a_comp_route: assert property (
      (take && is_comp) |=> wb_o.data == ~$past(req_i.file_data)
         && wb_o.file_we == $past(req_i.dest_file) && wb_o.zero_we)
      else $error("complement wrong");

   a_single_cycle_ops: assert property (
      (take && (is_comp || is_clear_file || is_clear_acc || is_dec)) |=> done_o
         && !busy_o && !discard_next_o && cycles_o == 2'h1)
      else $error("one-cycle instruction timing wrong");

   // Clears force zero and always set the flag
   a_clear_file: assert property (
      (take && is_clear_file) |=> wb_o.file_we && !wb_o.acc_we && wb_o.data == 8'h00
         && wb_o.zero_we && wb_o.zero)
      else $error("clear file wrong");

   a_clear_acc: assert property (
      (take && is_clear_acc) |=> wb_o.acc_we && !wb_o.file_we && wb_o.data == 8'h00
         && wb_o.zero_we && wb_o.zero)
      else $error("clear accumulator wrong");

   // Decrement wraps 00h to FFh
   a_dec_result: assert property (
      (take && is_dec) |=> wb_o.data == 8'($past(req_i.file_data) - 8'h01)
         && wb_o.acc_we == !$past(req_i.dest_file))
      else $error("decrement wrong");

   a_dec_zero_flag: assert property (
      (take && (is_comp || is_dec)) |=> wb_o.zero_we
         && wb_o.zero == (wb_o.data == 8'h00))
      else $error("zero flag not written");

   // Both directions, so a stuck flag shows as well as a missing one
   a_zero_flag: assert property (
      wb_o.zero_we |-> wb_o.zero == (wb_o.data == 8'h00))
      else $error("zero flag wrong");

   a_addr_routed: assert property (
      (take && (is_comp || is_step || is_clear_file)) |=> wb_o.file_addr
         == $past(req_i.file_addr))
      else $error("file address wrong");

   // Skip steps: flags untouched, skip only on a zero result
   a_skip_no_flags: assert property (
      (take && (is_dsz || is_isz)) |=> !wb_o.zero_we)
      else $error("skip step touched flags");

   a_dsz_route: assert property (
      (take && is_dsz) |=> wb_o.data == 8'($past(req_i.file_data) - 8'h01)
         && wb_o.file_we == $past(req_i.dest_file)
         && wb_o.acc_we == !$past(req_i.dest_file))
      else $error("decrement skip routing wrong");

   a_skip_on_zero: assert property (
      (take && is_dsz && req_i.file_data == 8'h01) |=> (discard_next_o
         && cycles_o == 2'h2) ##1 !busy_o)
      else $error("decrement skip missed");

   a_dsz_no_skip: assert property (
      (take && is_dsz && req_i.file_data != 8'h01) |=> !discard_next_o && !busy_o
         && cycles_o == 2'h1)
      else $error("decrement skip taken on nonzero");

   // The flushed slot must stay silent: no write, no completion
   a_flush_quiet: assert property (
      (state == ST_FLUSH) |=> !wb_o.acc_we && !wb_o.file_we && !done_o && !discard_next_o)
      else $error("flushed slot not silent");

   a_inc_skip: assert property (
      (take && is_isz) |=> discard_next_o == ($past(req_i.file_data) == 8'hFF))
      else $error("increment skip wrong");

   a_inc_route: assert property (
      (take && is_isz) |=> wb_o.data == 8'($past(req_i.file_data) + 8'h01)
         && wb_o.file_we == $past(req_i.dest_file) && !wb_o.zero_we)
      else $error("increment skip routing wrong");

   a_inc_two_cycles: assert property (
      (take && is_isz && req_i.file_data == 8'hFF) |=> (busy_o && cycles_o == 2'h2)
         ##1 !busy_o)
      else $error("increment skip not two cycles");

   // Main scenarios reached
   c_call: cover property (take && is_call ##2 done_o);
   c_dec_skip: cover property (take && is_dsz ##1 discard_next_o);
   c_inc_skip: cover property (take && is_isz ##1 discard_next_o);
   c_comp_file: cover property (take && is_comp && req_i.dest_file);
   c_refused: cover property (issue_i && busy_o);

endmodule // cpu_misc_instruction_exec

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import misc_exec_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic issue_i = 1'b0;
   exec_req_s req_i = '0;
   logic busy_o;
   logic done_o;
   logic discard_next_o;
   exec_wb_s wb_o;
   exec_flow_s flow_o;
   logic [1:0] cycles_o;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;

   // 200 MHz core clock
   always #2.5 sys_clk_i = ~sys_clk_i;

   cpu_misc_instruction_exec dut_u (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .issue_i(issue_i),
      .req_i(req_i),
      .busy_o(busy_o),
      .done_o(done_o),
      .discard_next_o(discard_next_o),
      .wb_o(wb_o),
      .flow_o(flow_o),
      .cycles_o(cycles_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, printed once from here only
   task automatic report_and_stop();
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard, far above the few dozen cycles the run needs
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // Four-state compare, so an unknown never matches
   task automatic chk(string what, logic [14:0] exp, logic [14:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Issue one instruction; returns just after the first answer edge.
   // With refuse set, a second request is raised while the call is busy.
   task automatic launch(misc_op_e op, logic [7:0] fd, logic dst, logic refuse);
      @(posedge sys_clk_i);
      issue_i <= 1'b1;
      req_i <= '{op, 7'h7F, dst, fd, 8'hA5, 7'h5A, 15'h7FFE};
      @(posedge sys_clk_i);
      issue_i <= refuse;
      req_i.op <= OP_CLEAR_ACCUMULATOR;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Call through the accumulator, with a request refused while busy
   task automatic t_call();
      launch(OP_CALL_VIA_ACCUMULATOR, 8'h00, 1'b0, 1'b1);
      chk("push", 15'h1, flow_o.push);
      chk("ret_addr", 15'h7FFF, flow_o.ret_addr);
      chk("pc_load first", 15'h0, flow_o.pc_load);
      chk("busy first", 15'h1, busy_o);
      chk("done first", 15'h0, done_o);
      chk("zero_we first", 15'h0, wb_o.zero_we);
      // Second cycle; the refused request was sampled at this edge
      @(posedge sys_clk_i);
      issue_i <= 1'b0;
      #1;
      chk("pc_load", 15'h1, flow_o.pc_load);
      chk("pc_target", 15'h5AA5, flow_o.pc_target);
      chk("push second", 15'h0, flow_o.push);
      chk("done", 15'h1, done_o);
      chk("cycles", 15'h2, cycles_o);
      chk("zero_we second", 15'h0, wb_o.zero_we);
      chk("busy second", 15'h0, busy_o);
      chk("refused acc_we", 15'h0, wb_o.acc_we);
      @(posedge sys_clk_i);
      #1;
      chk("refused done", 15'h0, done_o);
      chk("pc_target held", 15'h5AA5, flow_o.pc_target);
      chk("pc_load pulse", 15'h0, flow_o.pc_load);
   endtask

   // One data instruction and its write-back, flag and skip outcome
   task automatic alu(misc_op_e op, logic [7:0] fd, logic dst, logic [7:0] res, logic z);
      logic fw;
      logic zw;
      logic hit;
      fw = (op == OP_CLEAR_FILE) | (dst & (op != OP_CLEAR_ACCUMULATOR));
      zw = (op < OP_DECREMENT_SKIP_ZERO);
      hit = !zw && (res == 8'h00);
      launch(op, fd, dst, 1'b0);
      chk("data", {7'h00, res}, wb_o.data);
      chk("file_we", {14'h0, fw}, wb_o.file_we);
      chk("acc_we", {14'h0, !fw}, wb_o.acc_we);
      if (fw) chk("file_addr", 15'h7F, wb_o.file_addr);
      chk("zero_we", {14'h0, zw}, wb_o.zero_we);
      if (zw) chk("zero", {14'h0, z}, wb_o.zero);
      chk("discard", {14'h0, hit}, discard_next_o);
      chk("cycles", hit ? 15'h2 : 15'h1, cycles_o);
      chk("busy flush", {14'h0, hit}, busy_o);
      chk("done", 15'h1, done_o);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      // Reset held over four edges, released at the fourth
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk("reset done", 15'h0, done_o);
      chk("reset busy", 15'h0, busy_o);
      chk("reset discard", 15'h0, discard_next_o);
      chk("reset push", 15'h0, flow_o.push);
      chk("reset pc_load", 15'h0, flow_o.pc_load);
      chk("reset wb", 15'h0, {12'h000, wb_o.acc_we, wb_o.file_we, wb_o.zero_we});
      chk("reset cycles", 15'h0, {13'h0000, cycles_o});
      t_call();
      alu(OP_COMPLEMENT_FILE, 8'hFF, 1'b0, 8'h00, 1'b1);
      alu(OP_COMPLEMENT_FILE, 8'h5A, 1'b1, 8'hA5, 1'b0);
      alu(OP_CLEAR_FILE, 8'h3C, 1'b0, 8'h00, 1'b1);
      alu(OP_CLEAR_ACCUMULATOR, 8'h3C, 1'b1, 8'h00, 1'b1);
      alu(OP_DECREMENT_FILE, 8'h01, 1'b1, 8'h00, 1'b1);
      alu(OP_DECREMENT_FILE, 8'h00, 1'b0, 8'hFF, 1'b0);
      alu(OP_DECREMENT_SKIP_ZERO, 8'h01, 1'b0, 8'h00, 1'b0);
      alu(OP_DECREMENT_SKIP_ZERO, 8'h02, 1'b1, 8'h01, 1'b0);
      alu(OP_INCREMENT_SKIP_ZERO, 8'hFF, 1'b1, 8'h00, 1'b0);
      alu(OP_INCREMENT_SKIP_ZERO, 8'h7F, 1'b0, 8'h80, 1'b0);
      repeat (2) @(posedge sys_clk_i);
      report_and_stop();
   end
endmodule // tb_top
